// >>> rtl/smp_pkg.sv
// Shared constants for the switch monitor serial port and its event logic
package smp_pkg;

  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned DATA_W     = 24;
  localparam int unsigned FLAG_W     = 7;
  localparam int unsigned HDR_W      = 7;
  localparam int unsigned CODE_W     = 10;
  localparam int unsigned WET_N      = 4;
  localparam int unsigned BUF_W      = 32;

  // Frame layout on the serial input
  localparam int unsigned RW_BIT     = 31;
  localparam int unsigned ADDR_MSB   = 30;
  localparam int unsigned ADDR_LSB   = 25;
  localparam int unsigned DATA_MSB   = 24;
  localparam int unsigned DATA_LSB   = 1;
  localparam logic [5:0]  CNT_FULL   = 6'h20;
  localparam logic [5:0]  CNT_MAX    = 6'h3f;
  localparam logic [5:0]  ADDR_FALLS = 6'h06;
  localparam logic [5:0]  LAST_RISE  = 6'h1f;

  // Event flag positions
  localparam int unsigned FL_RST   = 6;
  localparam int unsigned FL_FRAME = 5;
  localparam int unsigned FL_PAR   = 4;
  localparam int unsigned FL_VS0   = 3;
  localparam int unsigned FL_VS1   = 2;
  localparam int unsigned FL_WET   = 1;
  localparam int unsigned FL_CONV  = 0;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 7'h40;

  // Register addresses and converter reference (plain defaults)
  localparam logic [ADDR_W-1:0] EVT_ADDR    = 6'h21;
  localparam logic [ADDR_W-1:0] WR_ADDR_MAX = 6'h1f;
  localparam logic [CODE_W-1:0] CONV_EXPECT = 10'h2aa;

  // Supply edge selection codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

endpackage : smp_pkg

// >>> rtl/smp_sync3.sv
// Two-flop synchronisers for the three serial link inputs
`timescale 1ns/1ps
module smp_sync3
  import smp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [2:0] asyncIn,
  output logic      [2:0] syncOut
);

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } smp_sync_s;

  smp_sync_s s_r;
  smp_sync_s s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.stage1 = asyncIn;
    s_nxt.stage2 = s_r.stage1;
  end

  // Idle levels: chip select high, clock and data low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '{stage1: 3'h4, stage2: 3'h4};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign syncOut = s_r.stage2;

endmodule : smp_sync3

// >>> rtl/smp_buf2.sv
// Two-entry buffer for accepted write frames
`timescale 1ns/1ps
module smp_buf2
  import smp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  input  wire logic [BUF_W-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [BUF_W-1:0] outData,
  input  wire logic             outReady
);

  typedef struct packed {
    logic [1:0][BUF_W-1:0] mem;
    logic                  wrPtr;
    logic                  rdPtr;
    logic [1:0]            count;
  } smp_buf_s;

  smp_buf_s s_r;
  smp_buf_s s_nxt;
  logic     doPush;
  logic     doPop;

  assign inReady  = (s_r.count != 2'h2);
  assign outValid = (s_r.count != 2'h0);
  assign outData  = s_r.mem[s_r.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb begin
    s_nxt = s_r;
    if (doPush) begin
      s_nxt.mem[s_r.wrPtr] = inData;
      s_nxt.wrPtr          = ~s_r.wrPtr;
    end
    if (doPop) begin
      s_nxt.rdPtr = ~s_r.rdPtr;
    end
    s_nxt.count = s_r.count + {1'b0, doPush} - {1'b0, doPop};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  buf_no_overflow_a: assert property (@(posedge sys_clk) disable iff (reset)
    s_r.count <= 2'h2) else $error("buffer count above depth");

endmodule : smp_buf2

// >>> rtl/smp_spi_events.sv
// Serial slave port of the switch monitor with supply, wetting and converter events
// Summary of operation
// R1 - First enabled supply measurement always flags both thresholds; alerts only if either pin mask is set.
// R2 - First measurement is the baseline; later events need a crossing.
// R3 - Per threshold edge select: rising, falling or both directions.
// R4 - Edge select zero: no flag and no alert for that threshold once the baseline measurement is taken.
// R5 - Pin mask zero: flag still set, alert pin not driven.
// R6 - Any supply flag set shows the supply header bit during frames.
// R7 - Supply measurement is disabled after every reset.
// R8 - Wetting check per input 0..3, sources on 0/1, sinks on 2/3.
// R9 - Wetting fault alerts, sets flag, other header bit and detail bits.
// R10 - Inputs not poll enabled are never wetting checked.
// R11 - Checked inputs keep wetting current one conversion time longer.
// R12 - Converter self test stores code, compares, flags and alerts on mismatch.
// R13 - Chip select fall enables output and snapshots the event flags.
// R14 - Chip select rise floats output; alert released if flags were read.
// R15 - Host changes chip select only with serial clock low.
// R16 - Input sampled on clock falls, output shifted on clock rises.
// R17 - Chip select high: clock and input ignored, output floats.
// R18 - Only exactly 32 bits accepted; else frame error flag and alert.
// R19 - No frame error when no clock edge occurred.
// R20 - Output high after select; first rise shows bit 31, then onward.
// R21 - Words move most significant bit first through the shift register.
// R22 - Host keeps serial clock at or below 4 MHz; the test host model runs it at 5 MHz.
// R23 - Frame: write flag, 6-bit address, 24 data bits, parity bit.
// R24 - Writes commit at frame end only if valid, writable and error free.
// R25 - Header mirrors event flags; reading them clears both.
// R26 - Bit 0 gives odd parity over the other 31 bits.
// R27 - Chip select and clock synchronised before any event logic uses them.
`timescale 1ns/1ps
module smp_spi_events
  import smp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              csN,
  input  wire logic              sclk,
  input  wire logic              si,
  output logic                   soOut,
  output logic                   soOe,
  output logic                   alertN,
  output logic      [ADDR_W-1:0] rdAddr,
  output logic                   rdAddrStb,
  input  wire logic [DATA_W-1:0] rdData,
  output logic                   cmdValid,
  output logic      [BUF_W-1:0]  cmdWord,
  input  wire logic              cmdReady,
  input  wire logic              supplyMeasureEnable,
  input  wire logic [1:0]        supplyThr0EdgeSel,
  input  wire logic [1:0]        supplyThr1EdgeSel,
  input  wire logic              supplyThr0PinMask,
  input  wire logic              supplyThr1PinMask,
  input  wire logic              supplyMeasDone,
  input  wire logic              supplyThr0Above,
  input  wire logic              supplyThr1Above,
  output logic                   supplyMeasActive,
  output logic                   supplyThr0State,
  output logic                   supplyThr1State,
  input  wire logic [WET_N-1:0]  wetCheckEnable,
  input  wire logic [WET_N-1:0]  chanPollEnable,
  input  wire logic              wetCheckDone,
  input  wire logic [WET_N-1:0]  wetCheckFail,
  output logic      [WET_N-1:0]  wetFaultDetail,
  output logic      [WET_N-1:0]  wetExtendOn,
  input  wire logic              converterCheckEnable,
  input  wire logic              convDone,
  input  wire logic [CODE_W-1:0] convCode,
  output logic      [CODE_W-1:0] converterTestCode,
  output logic                   converterBad
);

  typedef struct packed {
    logic [5:0]        bitCnt;
    logic [5:0]        riseCnt;
    logic [31:0]       rxSh;
    logic [31:0]       txWord;
    logic [FLAG_W-1:0] flagSnap;
    logic              csPrev;
    logic              sclkPrev;
    logic              soOut;
    logic              soOe;
    logic              alertN;
    logic [FLAG_W-1:0] flags;
    logic              baseValid;
    logic              thr0State;
    logic              thr1State;
    logic              measActive;
    logic [WET_N-1:0]  wetDetail;
    logic [WET_N-1:0]  wetExt;
    logic [CODE_W-1:0] convCode;
    logic              convBad;
    logic [ADDR_W-1:0] rdAddr;
    logic              rdAddrStb;
    logic              rdLate;
    logic              pend;
    logic [BUF_W-1:0]  pendWord;
  } smp_top_s;

  smp_top_s s_r;
  smp_top_s s_nxt;

  logic [2:0]        syncPins;
  logic              csS;
  logic              sclkS;
  logic              siS;
  logic              csFall;
  logic              csRise;
  logic              sclkRise;
  logic              sclkFall;
  logic              measEvt;
  logic              bufReady;
  logic [WET_N-1:0]  wetFail;
  logic [FLAG_W-1:0] setMask;
  logic [FLAG_W-1:0] clrMask;
  logic              alertSet;
  logic              alertRel;
  logic              evtRead;
  logic              push;

  function automatic logic [HDR_W-1:0] hdrOf(input logic [FLAG_W-1:0] f);
    hdrOf = {f[FL_RST], f[FL_FRAME], f[FL_PAR], 1'b0, f[FL_VS0] | f[FL_VS1], 1'b0,
             f[FL_WET] | f[FL_CONV]}; // R6 R9 R25
  endfunction : hdrOf

  // Odd parity: bit 0 makes the count of ones in the frame odd
  function automatic logic parityBit(input logic [30:0] w);
    parityBit = ~(^w); // R26
  endfunction : parityBit

  function automatic logic crossed(input logic [1:0] sel, input logic now,
                                   input logic prev);
    unique case (sel)
      EDGE_OFF:  crossed = 1'b0; // R4
      EDGE_RISE: crossed = now && !prev;
      EDGE_FALL: crossed = !now && prev;
      EDGE_BOTH: crossed = now != prev; // R3
    endcase
  endfunction : crossed

  smp_sync3 u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn ({csN, sclk, si}),
    .syncOut (syncPins)
  );

  assign csS      = syncPins[2]; // R27
  assign sclkS    = syncPins[1];
  assign siS      = syncPins[0];
  assign csFall   = s_r.csPrev && !csS;
  assign csRise   = !s_r.csPrev && csS;
  // Clock edges count only while selected and not at a select edge
  assign sclkRise = !s_r.sclkPrev && sclkS && !csS && !s_r.csPrev; // R17
  assign sclkFall = s_r.sclkPrev && !sclkS && !csS && !s_r.csPrev; // R17
  assign measEvt  = supplyMeasDone && s_r.measActive;
  assign wetFail  = wetCheckFail & wetCheckEnable & chanPollEnable; // R10
  assign evtRead  = !s_r.rxSh[RW_BIT] && (s_r.rxSh[ADDR_MSB:ADDR_LSB] == EVT_ADDR);

  always_comb begin
    s_nxt    = s_r;
    setMask  = '0;
    clrMask  = '0;
    alertSet = 1'b0;
    alertRel = 1'b0;
    push     = 1'b0;
    s_nxt.csPrev     = csS;
    s_nxt.sclkPrev   = sclkS;
    s_nxt.rdAddrStb  = 1'b0;
    s_nxt.rdLate     = s_r.rdAddrStb;
    s_nxt.measActive = supplyMeasureEnable;                       // R7
    s_nxt.wetExt     = wetCheckEnable & chanPollEnable;            // R8 R11

    if (csFall) begin
      s_nxt.soOe     = 1'b1;                                       // R13
      s_nxt.soOut    = 1'b1;                                       // R20
      s_nxt.bitCnt   = '0;
      s_nxt.riseCnt  = '0;
      s_nxt.flagSnap = s_r.flags;                                  // R13
      s_nxt.txWord   = {hdrOf(s_r.flags), 25'h0};                  // R25
    end

    if (sclkFall) begin
      s_nxt.rxSh = {s_r.rxSh[30:0], siS};                          // R16 R21
      if (s_r.bitCnt != CNT_MAX) begin
        s_nxt.bitCnt = s_r.bitCnt + 6'h01;                         // R18
      end
      if (s_r.bitCnt == ADDR_FALLS) begin
        s_nxt.rdAddr    = {s_r.rxSh[4:0], siS};                    // R23
        s_nxt.rdAddrStb = 1'b1;
      end
    end

    // Previous content is fetched two cycles after the address is known
    if (s_r.rdLate) begin
      if (s_r.rdAddr == EVT_ADDR) begin
        s_nxt.txWord[DATA_MSB:DATA_LSB] = {17'h0, s_r.flagSnap};
      end else begin
        s_nxt.txWord[DATA_MSB:DATA_LSB] = rdData;
      end
    end

    if (sclkRise) begin
      if (s_r.riseCnt == LAST_RISE) begin
        s_nxt.soOut = parityBit(s_r.txWord[31:1]);                 // R26
      end else if (s_r.riseCnt < LAST_RISE) begin
        s_nxt.soOut = s_r.txWord[5'(LAST_RISE - s_r.riseCnt)];     // R16 R20 R21
      end else begin
        s_nxt.soOut = 1'b0;
      end
      if (s_r.riseCnt != CNT_MAX) begin
        s_nxt.riseCnt = s_r.riseCnt + 6'h01;
      end
    end

    if (csRise) begin
      s_nxt.soOe  = 1'b0;                                          // R14 R17
      s_nxt.soOut = 1'b0;
      if (s_r.bitCnt != 6'h00) begin                               // R19
        if (s_r.bitCnt != CNT_FULL) begin
          setMask[FL_FRAME] = 1'b1;                                // R18
          alertSet          = 1'b1;
        end else if (parityBit(s_r.rxSh[31:1]) != s_r.rxSh[0]) begin
          setMask[FL_PAR] = 1'b1;                                  // R24
          alertSet        = 1'b1;
        end else if (evtRead) begin
          clrMask  = s_r.flagSnap;                                 // R25
          alertRel = 1'b1;                                         // R14
        end else if (s_r.rxSh[RW_BIT]
                     && s_r.rxSh[ADDR_MSB:ADDR_LSB] <= WR_ADDR_MAX) begin
          push = 1'b1;                                             // R24
        end
      end
    end

    if (measEvt) begin
      s_nxt.thr0State = supplyThr0Above;
      s_nxt.thr1State = supplyThr1Above;
      s_nxt.baseValid = 1'b1;                                      // R2
      if (!s_r.baseValid) begin
        setMask[FL_VS0] = 1'b1;                                    // R1
        setMask[FL_VS1] = 1'b1;
        alertSet = alertSet || supplyThr0PinMask || supplyThr1PinMask;
      end else begin
        if (crossed(supplyThr0EdgeSel, supplyThr0Above, s_r.thr0State)) begin
          setMask[FL_VS0] = 1'b1;                                  // R2 R3
          alertSet = alertSet || supplyThr0PinMask;                // R5
        end
        if (crossed(supplyThr1EdgeSel, supplyThr1Above, s_r.thr1State)) begin
          setMask[FL_VS1] = 1'b1;                                  // R2 R3
          alertSet = alertSet || supplyThr1PinMask;                // R5
        end
      end
    end

    if (wetCheckDone) begin
      s_nxt.wetDetail = wetFail;                                   // R9
      if (wetFail != '0) begin
        setMask[FL_WET] = 1'b1;                                    // R9
        alertSet        = 1'b1;
      end
    end

    if (convDone && converterCheckEnable) begin
      s_nxt.convCode = convCode;                                   // R12
      s_nxt.convBad  = (convCode != CONV_EXPECT);
      if (convCode != CONV_EXPECT) begin
        setMask[FL_CONV] = 1'b1;                                   // R12
        alertSet         = 1'b1;
      end
    end

    // A new event in the clearing cycle survives the clear
    s_nxt.flags = (s_r.flags & ~clrMask) | setMask;
    if (alertSet) begin
      s_nxt.alertN = 1'b0;
    end else if (alertRel) begin
      s_nxt.alertN = 1'b1;
    end

    // One frame is held while the buffer is full; a later write would replace it
    if (s_r.pend && bufReady) begin
      s_nxt.pend = 1'b0;
    end
    if (push) begin
      s_nxt.pend     = 1'b1;
      s_nxt.pendWord = s_r.rxSh;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_r        <= '0;
      s_r.csPrev <= 1'b1;
      s_r.alertN <= 1'b1;
      s_r.flags  <= FLAGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  smp_buf2 u_buf (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .inValid  (s_r.pend),
    .inData   (s_r.pendWord),
    .inReady  (bufReady),
    .outValid (cmdValid),
    .outData  (cmdWord),
    .outReady (cmdReady)
  );

  assign soOut             = s_r.soOut;
  assign soOe              = s_r.soOe;
  assign alertN            = s_r.alertN;
  assign rdAddr            = s_r.rdAddr;
  assign rdAddrStb         = s_r.rdAddrStb;
  assign supplyMeasActive  = s_r.measActive;
  assign supplyThr0State   = s_r.thr0State;
  assign supplyThr1State   = s_r.thr1State;
  assign wetFaultDetail    = s_r.wetDetail;
  assign wetExtendOn       = s_r.wetExt;
  assign converterTestCode = s_r.convCode;
  assign converterBad      = s_r.convBad;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  so_float_a: assert property (csRise |=> !soOe && !soOut) // R14
    else $error("output not floated after deselect");
  so_enable_a: assert property (csFall |=> soOe && soOut ##1 soOe) // R13
    else $error("output not enabled high after select");
  frame_len_a: assert property ( // R18
    csRise && s_r.bitCnt != 6'h00 && s_r.bitCnt != CNT_FULL |=> s_r.flags[FL_FRAME] && !alertN)
    else $error("short or long frame not flagged");
  no_clock_a: assert property ( // R19
    csRise && s_r.bitCnt == 6'h00 |=> s_r.flags[FL_FRAME] == $past(s_r.flags[FL_FRAME]))
    else $error("frame error flagged without clock");
  idle_quiet_a: assert property (csS && s_r.csPrev |=> $stable(s_r.bitCnt)) // R17
    else $error("bit count moved while deselected");
  first_meas_a: assert property ( // R1
    measEvt && !s_r.baseValid |=> s_r.flags[FL_VS0] && s_r.flags[FL_VS1] && s_r.baseValid)
    else $error("first supply measurement not flagged");
  edge_off_a: assert property ( // R4
    measEvt && s_r.baseValid && supplyThr0EdgeSel == EDGE_OFF && !csRise
    |=> s_r.flags[FL_VS0] == $past(s_r.flags[FL_VS0]))
    else $error("disabled threshold set its flag");
  alert_cause_a: assert property ( // R5
    !alertN && $past(alertN) |-> $past(alertSet))
    else $error("alert driven without unmasked event");
  wet_fault_a: assert property ( // R9
    wetCheckDone && wetFail != '0 |=> s_r.flags[FL_WET] && !alertN ##0 wetFaultDetail != '0)
    else $error("wetting fault not reported");
  conv_fault_a: assert property ( // R12
    convDone && converterCheckEnable && convCode != CONV_EXPECT
    |=> s_r.flags[FL_CONV] && converterBad && !alertN)
    else $error("converter mismatch not reported");
  first_bit_a: assert property ( // R20
    sclkRise && s_r.riseCnt == 6'h00 |=> soOut == s_r.txWord[31])
    else $error("first rising edge did not show bit 31");
  release_a: assert property (csRise && s_r.bitCnt == CNT_FULL && evtRead // R14
    && parityBit(s_r.rxSh[31:1]) == s_r.rxSh[0] && !alertSet |=> alertN)
    else $error("alert not released after flag read");

  read_frame_c: cover property (csRise && s_r.bitCnt == CNT_FULL && evtRead);
  write_push_c: cover property (push ##[1:20] cmdValid);
  frame_err_c:  cover property (csRise && s_r.bitCnt == 6'h1f);
  supply_evt_c: cover property (measEvt && s_r.baseValid ##1 s_r.flags[FL_VS1]);

endmodule : smp_spi_events

// >>> test/smp_host_model.sv
// Behavioural host that masters the four-wire serial link
`timescale 1ns/1ps
module smp_host_model (
  output logic      csN,
  output logic      sclk,
  output logic      si,
  input  wire logic so
);
  logic [31:0] rxWord;

  initial begin
    csN    = 1'b1;
    sclk   = 1'b0;
    si     = 1'b0;
    rxWord = 32'h0;
  end

  // Half period of 100 ns: every level lasts four system cycles, above the three the port needs
  task automatic xfer(input logic [31:0] word, input int nbits);
    csN = 1'b0;
    #100;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      si   = word[31-i];
      #100;
      sclk   = 1'b0;
      rxWord = {rxWord[30:0], so};
      #100;
    end
    csN = 1'b1;
    // Released data line shows the inverse so a stale value is never mistaken for data
    si = ~si;
    #250;
  endtask : xfer
endmodule : smp_host_model

// >>> test/tb.sv
// Self-checking bench for the serial port and its event logic
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb
  import smp_pkg::*;
;
  logic              sys_clk, reset, csN, sclk, si, soOut, soOe, alertN, rdAddrStb;
  logic [ADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] rdData;
  logic              cmdValid, cmdReady, supplyMeasureEnable, supplyMeasDone;
  logic [BUF_W-1:0]  cmdWord;
  logic [1:0]        supplyThr0EdgeSel, supplyThr1EdgeSel;
  logic              supplyThr0PinMask, supplyThr1PinMask, supplyThr0Above, supplyThr1Above;
  logic              supplyMeasActive, supplyThr0State, supplyThr1State, wetCheckDone;
  logic [WET_N-1:0]  wetCheckEnable, chanPollEnable, wetCheckFail, wetFaultDetail, wetExtendOn;
  logic              converterCheckEnable, convDone, converterBad;
  logic [CODE_W-1:0] convCode, converterTestCode;
  int                miscompares, comparisons, stbCount;
  wire               soWire = soOe ? soOut : 1'bz;

  smp_spi_events u_smp_spi_events (.sys_clk, .reset, .csN, .sclk, .si, .soOut, .soOe,
    .alertN, .rdAddr, .rdAddrStb, .rdData, .cmdValid, .cmdWord, .cmdReady,
    .supplyMeasureEnable, .supplyThr0EdgeSel, .supplyThr1EdgeSel, .supplyThr0PinMask,
    .supplyThr1PinMask, .supplyMeasDone, .supplyThr0Above, .supplyThr1Above,
    .supplyMeasActive, .supplyThr0State, .supplyThr1State, .wetCheckEnable, .chanPollEnable,
    .wetCheckDone, .wetCheckFail, .wetFaultDetail, .wetExtendOn, .converterCheckEnable,
    .convDone, .convCode, .converterTestCode, .converterBad);
  smp_host_model u_smp_host_model (.csN(csN), .sclk(sclk), .si(si), .so(soWire));

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rdAddrStb === 1'b1) stbCount++;

  function automatic logic [31:0] soWord(input logic [6:0] f, input logic [23:0] d);
    logic [31:0] w;
    w[31:1] = {f[6:4], 1'b0, f[3] | f[2], 1'b0, f[1] | f[0], d};
    w[0]    = ~^w[31:1];
    return w;
  endfunction : soWord

  function automatic logic [31:0] siWord(input logic rw, input logic [5:0] a,
                                         input logic [23:0] d);
    logic [31:0] w;
    w[31:1] = {rw, a, d};
    w[0]    = ~^w[31:1];
    return w;
  endfunction : siWord

  task automatic readEvt(input logic [6:0] f);
    u_smp_host_model.xfer(siWord(1'b0, EVT_ADDR, 24'h0), 32);
    @(negedge sys_clk);
    `CHK("evtWord", soWord(f, {17'h0, f}), u_smp_host_model.rxWord)
    `CHK("alertOff", 1'b1, alertN)
    `CHK("soOff", 1'b0, soOe)
  endtask : readEvt

  task automatic measure(input logic a0, input logic a1, input logic expAlertN);
    @(negedge sys_clk);
    supplyThr0Above = a0;
    supplyThr1Above = a1;
    supplyMeasDone  = 1'b1;
    @(negedge sys_clk);
    supplyMeasDone = 1'b0;
    @(negedge sys_clk);
    `CHK("supplyAlert", expAlertN, alertN)
    `CHK("thr0State", a0, supplyThr0State)
    `CHK("thr1State", a1, supplyThr1State)
  endtask : measure

  task automatic conv(input logic [CODE_W-1:0] code, input logic bad);
    @(negedge sys_clk);
    convCode = code;
    convDone = 1'b1;
    @(negedge sys_clk);
    convDone = 1'b0;
    @(negedge sys_clk);
    `CHK("convCode", code, converterTestCode)
    `CHK("convBad", bad, converterBad)
    `CHK("convAlert", ~bad, alertN)
  endtask : conv

  task automatic t_reset;
    `CHK("rstAlert", 1'b1, alertN)
    `CHK("rstMeas", 1'b0, supplyMeasActive)
    measure(1'b0, 1'b0, 1'b1);
    readEvt(FLAGS_RST);
    readEvt(7'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_supply;
    @(negedge sys_clk);
    supplyMeasureEnable = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK("measOn", 1'b1, supplyMeasActive)
    measure(1'b1, 1'b0, 1'b0);
    readEvt(7'h0c);
    measure(1'b1, 1'b0, 1'b1);
    supplyThr1PinMask = 1'b0;
    measure(1'b1, 1'b1, 1'b1);
    supplyThr0EdgeSel = EDGE_OFF;
    measure(1'b0, 1'b1, 1'b1);
    supplyThr0EdgeSel = EDGE_FALL;
    measure(1'b1, 1'b1, 1'b1);
    measure(1'b0, 1'b1, 1'b0);
    readEvt(7'h0c);
    supplyThr0EdgeSel = EDGE_RISE;
    measure(1'b1, 1'b0, 1'b0);
    readEvt(7'h0c);
    supplyMeasureEnable = 1'b0;
    $display("test supply done");
  endtask : t_supply

  task automatic t_diag;
    @(negedge sys_clk);
    wetCheckEnable       = 4'h3;
    chanPollEnable       = 4'h5;
    converterCheckEnable = 1'b1;
    wetCheckFail         = 4'hf;
    wetCheckDone         = 1'b1;
    @(negedge sys_clk);
    wetCheckDone = 1'b0;
    @(negedge sys_clk);
    `CHK("wetExtend", 4'h1, wetExtendOn)
    `CHK("wetDetail", 4'h1, wetFaultDetail)
    `CHK("wetAlert", 1'b0, alertN)
    readEvt(7'h02);
    conv(CONV_EXPECT, 1'b0);
    conv(10'h155, 1'b1);
    readEvt(7'h01);
    $display("test diag done");
  endtask : t_diag

  task automatic t_frame;
    u_smp_host_model.xfer(siWord(1'b0, EVT_ADDR, 24'h0), 0);
    `CHK("noClkAlert", 1'b1, alertN)
    u_smp_host_model.xfer(siWord(1'b0, EVT_ADDR, 24'h0), 31);
    `CHK("shortAlert", 1'b0, alertN)
    u_smp_host_model.xfer(siWord(1'b1, 6'h05, 24'h1) ^ 32'h1, 32);
    u_smp_host_model.xfer(siWord(1'b1, EVT_ADDR, 24'h1), 32);
    `CHK("noCmd", 1'b0, cmdValid)
    readEvt(7'h30);
    $display("test frame done");
  endtask : t_frame

  task automatic t_write;
    logic [31:0] w1, w2;
    w1       = siWord(1'b1, 6'h05, 24'h123456);
    w2       = siWord(1'b1, WR_ADDR_MAX, 24'habcdef);
    stbCount = 0;
    u_smp_host_model.xfer(w1, 32);
    `CHK("prevData", soWord(7'h0, rdData), u_smp_host_model.rxWord)
    `CHK("addr", 6'h05, rdAddr)
    u_smp_host_model.xfer(w2, 32);
    `CHK("stbCount", 2, stbCount)
    @(negedge sys_clk);
    `CHK("head1", w1, cmdWord)
    cmdReady = 1'b1;
    @(negedge sys_clk);
    `CHK("head2", w2, cmdWord)
    @(negedge sys_clk);
    cmdReady = 1'b0;
    `CHK("drained", 1'b0, cmdValid)
    $display("test write done");
  endtask : t_write

  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {sys_clk, supplyMeasureEnable, supplyMeasDone, supplyThr0Above, supplyThr1Above} = '0;
    {wetCheckEnable, chanPollEnable, wetCheckFail, wetCheckDone, convDone, convCode} = '0;
    {converterCheckEnable, cmdReady, miscompares, comparisons, stbCount} = '0;
    {supplyThr0PinMask, supplyThr1PinMask} = 2'h3;
    supplyThr0EdgeSel = EDGE_RISE;
    supplyThr1EdgeSel = EDGE_BOTH;
    rdData            = 24'h5a5a5a;
    reset             = 1'b1;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_supply();
    t_diag();
    t_frame();
    t_write();
    end_of_test();
  end

  // About fifteen frames of 7 us each; the limit leaves ample margin
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
endmodule : tb
